/* File: core/codec_sample_frame_sync.sv */
// Codec sample synchroniser on the framed serial bus, with an AXI4-Lite
// register slave. Assumes bus clock pin well below clk/8.
// Summary of operation
// - Sample moments from bus clock and divisors.
// - Counters start frame after path enable.
// - Audio bits 11-0, telecom bits 45-32.
// - Audio valid bit 30, telecom bit 31.
// - Use samples only when valid flag set.
// - Hand samples on during sixty-fourth bit.
// - Divisor multiple of four locks frame rate.
// - Sidetone cancel follows its enable bit.
// - Audio sample 12 bits, MSB at bit 0.
// - Telecom sample 14 bits from bit 32.
// - Control writes apply at sixty-fourth bit.
// - Sample in on falling, drive on rising.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "codec_sync_regs.svh"
module codec_sample_frame_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`CS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`CS_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic bus_clock_pin,
    input wire logic frame_start_pulse,
    input wire logic frame_data_in,
    output logic frame_data_out,
    output logic [`CS_AUD_W-1:0] audio_sample,
    output logic audio_sample_valid,
    input wire logic audio_sample_ready,
    output logic [`CS_TEL_W-1:0] tel_sample,
    output logic tel_sample_valid,
    input wire logic tel_sample_ready,
    output logic audio_moment,
    output logic tel_moment,
    output logic sidetone_cancel_enable
);
    import codec_sync_pkg::*;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_s3_q;
    logic [2:0] pin_q;
    logic [2:0] pin_prev_q;
    logic bclk_rise;
    logic bclk_fall;

    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
            pin_q <= '0;
            pin_prev_q <= '0;
        end else begin
            pin_s1_q <= {frame_data_in, frame_start_pulse, bus_clock_pin};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            for (int i = 0; i < 3; i++) begin
                if (pin_s2_q[i] == pin_s3_q[i]) begin
                    pin_q[i] <= pin_s3_q[i];
                end
            end
            pin_prev_q <= pin_q;
        end
    end
    assign bclk_rise = pin_q[0] & ~pin_prev_q[0];
    assign bclk_fall = ~pin_q[0] & pin_prev_q[0];

    // ****************************************************************
    // Frame tracking and inbound capture
    // ****************************************************************
    link_state_e link_q;
    logic [5:0] bit_q;
    logic [63:0] frame_q;
    logic frame_end;
    logic frame_begin;

    assign frame_end = bclk_fall && link_q == LINK_INFRAME &&
        bit_q == `CS_FR_LAST;
    assign frame_begin = bclk_fall && link_q == LINK_ARMED;

    // Sync arms the tracker; data sampled on falling edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link_q <= LINK_IDLE;
            bit_q <= '0;
            frame_q <= '0;
        end else begin
            if (bclk_rise && pin_q[1]) begin
                link_q <= LINK_ARMED;
            end else if (bclk_fall) begin
                unique case (link_q)
                    LINK_IDLE: ;
                    LINK_ARMED: begin
                        link_q <= LINK_INFRAME;
                        frame_q[0] <= pin_q[2];
                        bit_q <= 6'd1;
                    end
                    LINK_INFRAME: begin
                        frame_q[bit_q] <= pin_q[2];
                        bit_q <= bit_q + 6'd1;
                        if (bit_q == `CS_FR_LAST) begin
                            link_q <= LINK_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Outbound: only valid flags, driven on rising edges
    logic [`CS_CTRL_W-1:0] ctrl_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_data_out <= 1'b0;
        end else if (bclk_rise) begin
            frame_data_out <= (bit_q == 6'(`CS_FR_AUD_VLD) &&
                ctrl_q[`CS_F_AUD_IN]) || (bit_q == 6'(`CS_FR_TEL_VLD) &&
                ctrl_q[`CS_F_TEL_IN]);
        end
    end

    // ****************************************************************
    // Inbound sample extraction and buffering
    // ****************************************************************
    logic [`CS_AUD_W-1:0] aud_word;
    logic [`CS_TEL_W-1:0] tel_word;
    logic aud_push;
    logic tel_push;
    logic aud_in_ready;
    logic tel_in_ready;
    logic aud_ovr_q;
    logic tel_ovr_q;

    // MSB arrives first, so bit order reverses
    always_comb begin
        aud_word = '0;
        tel_word = '0;
        for (int i = 0; i < `CS_AUD_W; i++) begin
            aud_word[`CS_AUD_W-1-i] = frame_q[`CS_FR_AUD_MSB+i];
        end
        for (int i = 0; i < `CS_TEL_W; i++) begin
            tel_word[`CS_TEL_W-1-i] = frame_q[`CS_FR_TEL_MSB+i];
        end
    end

    // Push at the last bit only when flagged valid
    assign aud_push = frame_end && frame_q[`CS_FR_AUD_VLD];
    assign tel_push = frame_end && frame_q[`CS_FR_TEL_VLD];

    pair_buffer #(.W(`CS_AUD_W)) u_aud_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(aud_push),
        .in_ready(aud_in_ready),
        .in_data(aud_word),
        .out_valid(audio_sample_valid),
        .out_ready(audio_sample_ready),
        .out_data(audio_sample)
    );

    pair_buffer #(.W(`CS_TEL_W)) u_tel_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(tel_push),
        .in_ready(tel_in_ready),
        .in_data(tel_word),
        .out_valid(tel_sample_valid),
        .out_ready(tel_sample_ready),
        .out_data(tel_sample)
    );

    // A full buffer cannot stall the frame, so the loss is flagged
    logic ovr_clr;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aud_ovr_q <= 1'b0;
            tel_ovr_q <= 1'b0;
        end else begin
            if (aud_push && !aud_in_ready) begin
                aud_ovr_q <= 1'b1;
            end else if (ovr_clr) begin
                aud_ovr_q <= 1'b0;
            end
            if (tel_push && !tel_in_ready) begin
                tel_ovr_q <= 1'b1;
            end else if (ovr_clr) begin
                tel_ovr_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Control application and sample counters
    // ****************************************************************
    logic [`CS_CTRL_W-1:0] ctrl_pend_q;
    divisor_t audio_rate_divisor_q;
    divisor_t tel_div_q;
    divisor_t aud_cnt_q;
    divisor_t tel_cnt_q;
    logic aud_run_q;
    logic tel_run_q;
    logic aud_on;
    logic tel_on;
    logic tick;

    // Staged control lands at the last bit of a frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `CS_CTRL_RST;
            sidetone_cancel_enable <= 1'b0;
        end else begin
            if (frame_end) begin
                ctrl_q <= ctrl_pend_q;
            end
            sidetone_cancel_enable <= ctrl_q[`CS_F_SIDETONE];
        end
    end

    assign aud_on = ctrl_q[`CS_F_AUD_IN] | ctrl_q[`CS_F_AUD_OUT];
    assign tel_on = ctrl_q[`CS_F_TEL_IN] | ctrl_q[`CS_F_TEL_OUT];
    // One tick per 16 bus clocks: divisor 4 gives one per frame
    assign tick = bclk_fall && link_q == LINK_INFRAME &&
        bit_q[3:0] == `CS_TICK_MASK;

    // Start at next frame begin; idle codec held at zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aud_run_q <= 1'b0;
            tel_run_q <= 1'b0;
        end else begin
            if (!aud_on) begin
                aud_run_q <= 1'b0;
            end else if (frame_begin) begin
                aud_run_q <= 1'b1;
            end
            if (!tel_on) begin
                tel_run_q <= 1'b0;
            end else if (frame_begin) begin
                tel_run_q <= 1'b1;
            end
        end
    end

    // Count 0..divisor-1, moment pulse on wrap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aud_cnt_q <= '0;
            tel_cnt_q <= '0;
            audio_moment <= 1'b0;
            tel_moment <= 1'b0;
        end else begin
            audio_moment <= 1'b0;
            tel_moment <= 1'b0;
            if (!aud_run_q) begin
                aud_cnt_q <= '0;
            end else if (tick) begin
                if (aud_cnt_q + 8'd1 >= audio_rate_divisor_q) begin
                    aud_cnt_q <= '0;
                    audio_moment <= 1'b1;
                end else begin
                    aud_cnt_q <= aud_cnt_q + 8'd1;
                end
            end
            if (!tel_run_q) begin
                tel_cnt_q <= '0;
            end else if (tick) begin
                if (tel_cnt_q + 8'd1 >= tel_div_q) begin
                    tel_cnt_q <= '0;
                    tel_moment <= 1'b1;
                end else begin
                    tel_cnt_q <= tel_cnt_q + 8'd1;
                end
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite register slave
    // ****************************************************************
    logic [`CS_ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_have_q;
    logic w_have_q;
    logic do_write;
    logic wmap;

    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wmap = waddr_q == `CS_OFS_CTRL || waddr_q == `CS_OFS_AUDIO_RATE_DIVISOR ||
        waddr_q == `CS_OFS_TEL_DIV || waddr_q == `CS_OFS_STATUS;
    assign ovr_clr = do_write && waddr_q == `CS_OFS_STATUS && wstrb_q[0];

    // Address and data taken in either order, one write in flight
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CS_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                waddr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wmap ? `CS_RESP_OKAY : `CS_RESP_SLVERR;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Register contents; divisors follow writes at once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_pend_q <= `CS_CTRL_RST;
            audio_rate_divisor_q <= `CS_DIV_RST;
            tel_div_q <= `CS_DIV_RST;
        end else if (do_write && wstrb_q[0]) begin
            if (waddr_q == `CS_OFS_CTRL) begin
                ctrl_pend_q <= wdata_q[`CS_CTRL_W-1:0];
            end
            if (waddr_q == `CS_OFS_AUDIO_RATE_DIVISOR) begin
                audio_rate_divisor_q <= wdata_q[`CS_DIV_W-1:0];
            end
            if (waddr_q == `CS_OFS_TEL_DIV) begin
                tel_div_q <= wdata_q[`CS_DIV_W-1:0];
            end
        end
    end

    // Read side; unmapped addresses answer SLVERR with zero data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `CS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `CS_RESP_OKAY;
            s_axi_rdata <= '0;
            unique case (s_axi_araddr)
                `CS_OFS_CTRL: s_axi_rdata <= {27'h0, ctrl_pend_q};
                `CS_OFS_AUDIO_RATE_DIVISOR: s_axi_rdata <= {24'h0, audio_rate_divisor_q};
                `CS_OFS_TEL_DIV: s_axi_rdata <= {24'h0, tel_div_q};
                `CS_OFS_STATUS: s_axi_rdata <= {28'h0, tel_ovr_q, aud_ovr_q,
                    tel_run_q, aud_run_q};
                `CS_OFS_COUNT: s_axi_rdata <= {16'h0, tel_cnt_q, aud_cnt_q};
                default: s_axi_rresp <= `CS_RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    aud_wrap_a: assert property (@(posedge clk) disable iff (rst)
        aud_run_q && tick && aud_cnt_q + 8'd1 >= audio_rate_divisor_q |=>
        audio_moment && aud_cnt_q == 8'd0)
        else $error("audio counter did not wrap");
    tel_wrap_a: assert property (@(posedge clk) disable iff (rst)
        tel_moment |-> $past(tel_run_q) && $past(tick))
        else $error("telecom moment without tick");
    idle_hold_a: assert property (@(posedge clk) disable iff (rst)
        !aud_on ##1 !aud_on |=> aud_cnt_q == 8'd0 && !aud_run_q)
        else $error("idle audio counter not held");
    start_frame_a: assert property (@(posedge clk) disable iff (rst)
        $rose(aud_run_q) |-> $past(frame_begin))
        else $error("audio counter started off frame");
    ctrl_apply_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_q != $past(ctrl_q) |-> $past(frame_end))
        else $error("control changed away from last bit");
    valid_gate_a: assert property (@(posedge clk) disable iff (rst)
        frame_end && !frame_q[`CS_FR_AUD_VLD] |=>
        audio_sample_valid == $past(audio_sample_valid) ||
        $past(audio_sample_ready))
        else $error("invalid audio sample was pushed");
    push_time_a: assert property (@(posedge clk) disable iff (rst)
        $rose(tel_sample_valid) |-> $past(frame_end))
        else $error("telecom sample outside last bit");
    side_follow_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_q[`CS_F_SIDETONE] ##1 ctrl_q[`CS_F_SIDETONE] |->
        sidetone_cancel_enable)
        else $error("sidetone cancel not following enable");
    resp_wait_a: assert property (@(posedge clk) disable iff (rst)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
endmodule

/* File: core/codec_sync_pkg.sv */
// Types shared by the codec sample synchroniser.
// Assumes the constants header is included where numbers are needed.
package codec_sync_pkg;

    // Frame tracker position, Gray along idle -> armed -> in frame
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_ARMED = 2'b01,
        LINK_INFRAME = 2'b11
    } link_state_e;

    typedef logic [7:0] divisor_t;

endpackage

/* File: core/codec_sync_regs.svh */
// Named offsets, field positions, reset values and counts for the codec
// sample synchroniser. Assumes inclusion by bare name from core/ sources.
`ifndef CODEC_SYNC_REGS_SVH
`define CODEC_SYNC_REGS_SVH

// ****************************************************************
// Register map (byte addresses on the register bus)
// ****************************************************************
`define CS_ADDR_W 8
`define CS_OFS_CTRL 8'h00
`define CS_OFS_AUDIO_RATE_DIVISOR 8'h04
`define CS_OFS_TEL_DIV 8'h08
`define CS_OFS_STATUS 8'h0c
`define CS_OFS_COUNT 8'h10

// ****************************************************************
// Control and status fields
// ****************************************************************
`define CS_F_AUD_IN 0
`define CS_F_AUD_OUT 1
`define CS_F_TEL_IN 2
`define CS_F_TEL_OUT 3
`define CS_F_SIDETONE 4
`define CS_CTRL_W 5
`define CS_CTRL_RST 5'h00
`define CS_DIV_W 8
`define CS_DIV_RST 8'h08
`define CS_ST_AUD_RUN 0
`define CS_ST_TEL_RUN 1
`define CS_ST_AUD_OVR 2
`define CS_ST_TEL_OVR 3

// ****************************************************************
// Frame layout and timing
// ****************************************************************
`define CS_FR_LAST 6'd63
`define CS_FR_AUD_MSB 0
`define CS_AUD_W 12
`define CS_FR_TEL_MSB 32
`define CS_TEL_W 14
`define CS_FR_AUD_VLD 30
`define CS_FR_TEL_VLD 31
`define CS_TICK_MASK 4'hf
`define CS_RESP_OKAY 2'b00
`define CS_RESP_SLVERR 2'b10

`endif

/* File: core/pair_buffer.sv */
// Two-entry valid/ready buffer for one sample stream.
// Assumes one clock and asynchronous active-high reset.
`timescale 1ns/1ps
module pair_buffer #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic v0_q;
    logic v1_q;
    logic [W-1:0] d0_q;
    logic [W-1:0] d1_q;
    logic push;
    logic pop;

    // Ready only from the second slot, so a stall never drops a word
    assign in_ready = ~v1_q;
    assign out_valid = v0_q;
    assign out_data = d0_q;
    assign push = in_valid & ~v1_q;
    assign pop = v0_q & out_ready;

    // Slot update: head leaves on pop, tail moves forward
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            v0_q <= 1'b0;
            v1_q <= 1'b0;
            d0_q <= '0;
            d1_q <= '0;
        end else if (push && pop) begin
            if (v1_q) begin
                d0_q <= d1_q;
                d1_q <= in_data;
            end else begin
                d0_q <= in_data;
            end
        end else if (push) begin
            if (!v0_q) begin
                d0_q <= in_data;
                v0_q <= 1'b1;
            end else begin
                d1_q <= in_data;
                v1_q <= 1'b1;
            end
        end else if (pop) begin
            d0_q <= d1_q;
            v0_q <= v1_q;
            v1_q <= 1'b0;
        end
    end
endmodule

/* File: tb/frame_ctrl_model.sv */
// Controller side of the framed serial bus: one 64-bit frame per request.
// Assumes start is a one-cycle request and the clock is the bench clk.
`timescale 1ns/1ps
module frame_ctrl_model (
    input wire logic clk,
    input wire logic start,
    input wire logic [63:0] word,
    input wire logic dout,
    output logic [63:0] rx,
    output logic busy,
    output logic bus_clk,
    output logic sync,
    output logic data
);
    int i;
    // ********************************************
    // Frame generator
    // ********************************************
    // Bus clock of 10 clk periods, parked low between frames
    initial begin
        busy = 1'b0;
        bus_clk = 1'b0;
        sync = 1'b0;
        data = 1'b0;
        forever begin
            @(posedge clk);
            if (start) begin
                busy <= 1'b1;
                for (i = 0; i < 64; i++) begin
                    sync <= (i == 0);
                    data <= word[i];
                    bus_clk <= 1'b1;
                    repeat (5) @(posedge clk);
                    bus_clk <= 1'b0;
                    repeat (5) @(posedge clk);
                    rx[i] <= dout; // Outbound bit settled by bit end
                end
                data <= ~word[63]; // Released line shows no stale bit
                busy <= 1'b0;
            end
        end
    end
endmodule

/* File: tb/test_codec_sample_frame_sync.sv */
// Self-checking bench for the codec sample synchroniser.
// Assumes core/ is on the include path.
`timescale 1ns/1ps
`include "codec_sync_regs.svh"
module test_codec_sample_frame_sync;
    logic clk, rst, go, busy, en_rdy;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, bus_clock_pin, frame_start_pulse;
    logic frame_data_in, frame_data_out, audio_sample_valid;
    logic [11:0] audio_sample;
    logic [13:0] tel_sample;
    logic audio_sample_ready, tel_sample_valid, tel_sample_ready;
    logic audio_moment, tel_moment, sidetone_cancel_enable;
    logic [63:0] word, rx;
    int fail_count, num_checks, am, tm, n;
    int aq[$], tq[$];

    // ********************************************
    // Design, far side and clock
    // ********************************************
    codec_sample_frame_sync dut_u (.clk, .rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .bus_clock_pin, .frame_start_pulse, .frame_data_in,
        .frame_data_out, .audio_sample, .audio_sample_valid,
        .audio_sample_ready, .tel_sample, .tel_sample_valid,
        .tel_sample_ready, .audio_moment, .tel_moment,
        .sidetone_cancel_enable);
    frame_ctrl_model ctrl_u (.clk, .start(go), .word, .busy, .rx,
        .dout(frame_data_out), .bus_clk(bus_clock_pin),
        .sync(frame_start_pulse), .data(frame_data_in));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ********************************************
    // Checking and closing
    // ********************************************
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic spin(input bit ok);
        if (!ok) begin
            fail_count++;
            end_sim();
        end
    endtask

    // ********************************************
    // Register bus master
    // ********************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50 && !(s_axi_bready && s_axi_bvalid); n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        spin(n < 50);
        check(s_axi_bresp, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50 && !(s_axi_rready && s_axi_rvalid); n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        rd_v = s_axi_rdata;
        spin(n < 50);
        check(s_axi_rresp, r);
    endtask

    // ********************************************
    // Frames and the sample model
    // ********************************************
    // Reference queues mirror the two-entry buffers; a full one drops
    task automatic send(input bit fa, input bit ft);
        logic [11:0] a;
        logic [13:0] t;
        logic [63:0] w;
        int i;
        a = $urandom;
        t = $urandom;
        w = {$urandom, $urandom};
        for (i = 0; i < 12; i++) w[i] = a[11-i];
        for (i = 0; i < 14; i++) w[32+i] = t[13-i];
        w[30] = fa;
        w[31] = ft;
        @(posedge clk);
        word <= w;
        go <= 1'b1;
        if (fa && aq.size() < 2) aq.push_back(a);
        if (ft && tq.size() < 2) tq.push_back(t);
        @(posedge clk);
        go <= 1'b0;
        for (n = 0; n < 900 && (busy !== 1'b0 || n < 2); n++) @(posedge clk);
        spin(n < 900);
        repeat (20) @(posedge clk);
    endtask
    // Filter side takes samples at random moments
    always @(posedge clk) begin
        if (audio_sample_valid && audio_sample_ready)
            check(audio_sample, aq.size() ? aq.pop_front() : -1);
        if (tel_sample_valid && tel_sample_ready)
            check(tel_sample, tq.size() ? tq.pop_front() : -1);
        if (audio_moment === 1'b1) am++;
        if (tel_moment === 1'b1) tm++;
        audio_sample_ready <= en_rdy & $urandom % 2;
        tel_sample_ready <= en_rdy & $urandom % 2;
    end

    // ********************************************
    // Main sequence
    // ********************************************
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, go, en_rdy} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        word = 64'h0;
        rst = 1'b1;
        void'($urandom(74));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(`CS_OFS_CTRL, `CS_RESP_OKAY);
        check(rd_v, 32'h0);
        rd(`CS_OFS_AUDIO_RATE_DIVISOR, `CS_RESP_OKAY);
        check(rd_v, 32'h8);
        rd(8'h14, `CS_RESP_SLVERR);
        check(rd_v, 32'h0);
        wr(8'h14, 32'h1f, `CS_RESP_SLVERR);
        wr(`CS_OFS_AUDIO_RATE_DIVISOR, 32'h4, `CS_RESP_OKAY);
        wr(`CS_OFS_TEL_DIV, 32'h8, `CS_RESP_OKAY);
        en_rdy <= 1'b1;
        wr(`CS_OFS_CTRL, 32'h15, `CS_RESP_OKAY);
        check(sidetone_cancel_enable, 1'b0);
        send(1'b0, 1'b0);
        check(rx[31:0], 32'h0);
        check(sidetone_cancel_enable, 1'b1);
        check(am, 0);
        repeat (4) send($urandom % 2, $urandom % 2);
        check(am, 4);
        check(tm, 2);
        en_rdy <= 1'b0;
        repeat (20) @(posedge clk);
        repeat (3) send(1'b1, 1'b1);
        rd(`CS_OFS_STATUS, `CS_RESP_OKAY);
        check(rd_v, 32'hf);
        en_rdy <= 1'b1;
        repeat (20) @(posedge clk);
        check(aq.size() + tq.size(), 0);
        wr(`CS_OFS_STATUS, 32'h0, `CS_RESP_OKAY);
        rd(`CS_OFS_STATUS, `CS_RESP_OKAY);
        check(rd_v, 32'h3);
        // Output paths alone keep both counters running
        wr(`CS_OFS_CTRL, 32'ha, `CS_RESP_OKAY);
        send(1'b0, 1'b0);
        check(rx[31:0], 32'hc0000000);
        wr(`CS_OFS_CTRL, 32'h0, `CS_RESP_OKAY);
        send(1'b0, 1'b0);
        check(rx[31:0], 32'h0);
        check(sidetone_cancel_enable, 1'b0);
        check(am, 9);
        check(tm, 4);
        rd(`CS_OFS_COUNT, `CS_RESP_OKAY);
        check(rd_v, 32'h0);
        end_sim();
    end
endmodule
